// File: rtl/exception_vector_pkg.sv
// Purpose: Shared constants and types for the exception vector selector
// Assumes: 64-bit handler addresses, 32-bit register bus
// Notes:   Vector offsets are fixed by the exception map, not configurable
package exception_vector_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [11:0] VP_RESET_BASE_OFS   = 12'h020;
   localparam logic [11:0] CORE_BOOT_BASE_OFS  = 12'h680;
   localparam logic [11:0] LAST_VECTOR_LO_OFS  = 12'h700;
   localparam logic [11:0] LAST_VECTOR_HI_OFS  = 12'h704;
   localparam logic [11:0] TAKEN_STATUS_OFS    = 12'h708;
   localparam logic [31:0] VP_RESET_BASE_RST   = 32'hBFC0_0000;
   localparam logic [31:0] CORE_BOOT_BASE_RST  = 32'hBFC0_0000;
   localparam int          USE_BOOT_BASE_BIT   = 0;
   localparam int          CLASS_FIELD_LSB     = 8;

   // ****************************************************************
   // Vectors and offsets
   // ****************************************************************
   localparam logic [31:0] UPPER_ONES          = 32'hFFFF_FFFF;
   localparam logic [63:0] NMI_VECTOR          = 64'hFFFF_FFFF_BFC0_0000;
   localparam logic [63:0] DEBUG_FIXED_VECTOR  = 64'hFFFF_FFFF_BFC0_0480;
   localparam logic [63:0] PROBE_VECTOR        = 64'hFFFF_FFFF_FF20_0200;
   localparam logic [11:0] OFS_TLB_REFILL      = 12'h000;
   localparam logic [11:0] OFS_GENERAL         = 12'h180;
   localparam logic [11:0] OFS_INT_DEDICATED   = 12'h200;
   localparam logic [11:0] OFS_CACHE_ERR       = 12'h100;
   localparam logic [11:0] BOOT_OFS_TLB        = 12'h200;
   localparam logic [11:0] BOOT_OFS_TLB_LEVEL  = 12'h380;
   localparam logic [11:0] BOOT_OFS_CACHE_ERR  = 12'h300;
   localparam logic [11:0] BOOT_OFS_GENERAL    = 12'h380;
   localparam logic [11:0] BOOT_OFS_INT_DEDIC  = 12'h400;
   localparam logic [4:0]  EXC_CODE_INTERRUPT  = 5'h00;

   // ****************************************************************
   // Types
   // ****************************************************************
   localparam int NUM_CLASSES = 8;

   // Index order is priority order, index 0 highest
   typedef enum logic [2:0] {
      CLS_RESET      = 3'b000,
      CLS_NMI        = 3'b001,
      CLS_DEBUG      = 3'b010,
      CLS_CACHE_ERR  = 3'b011,
      CLS_TLB_REFILL = 3'b100,
      CLS_INTERRUPT  = 3'b101,
      CLS_OTHER      = 3'b110,
      CLS_BUS_ERR    = 3'b111
   } exc_class_t;

   typedef struct packed {
      logic bootVectorFlag;
      logic exceptionLevelFlag;
      logic dedicatedInterruptVectorFlag;
      logic debugSegmentEnable;
      logic probeTrapSelect;
      logic relocatedDebugVectorEnable;
   } exc_flags_t;

   typedef struct packed {
      logic [63:0] vector;
      exc_class_t  cls;
      logic [4:0]  code;
      logic        codeWrite;
   } vector_result_t;

endpackage

// File: rtl/exception_priority_pick.sv
// Purpose: Fixed-priority pick of one raised exception class
// Assumes: Bit 0 of the request vector has the highest priority
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module exception_priority_pick #(
   parameter int N = 8
) (
   input  wire logic [N-1:0]         raise,   // Raised conditions
   output logic      [N-1:0]         grant,   // One-hot winner
   output logic      [$clog2(N)-1:0] index,   // Winner index
   output logic                      any      // Something raised
);

   generate
      if (N < 2) begin : gBadWidth
         $error("exception_priority_pick needs at least two inputs");
      end
   endgenerate

   logic [N:0] blocked;

   assign blocked[0] = 1'b0;

   // ****************************************************************
   // Priority chain
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gPick
         assign grant[g]     = raise[g] & ~blocked[g];
         assign blocked[g+1] = blocked[g] | raise[g];
      end
   endgenerate

   always_comb begin
      index = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (grant[i]) begin
            index = i[$clog2(N)-1:0];
         end
      end
   end

   assign any = blocked[N];

endmodule // exception_priority_pick
`default_nettype wire

// File: rtl/exception_vector_select.sv
// Purpose: Handler address and cause code for the exception taken
// Assumes: Pipeline raises classes and flags on sys_clk, AHB-Lite slave
// Notes:   Result appears one cycle after the raise
//
// Summary of operation
// - Reset, select bit 0 clear: vector from the per-VP reset base register.
// - Boot-mode vectors use one core boot base register at 0x680.
// - Debug, segment off, relocation off: fixed vector ending 0480.
// - Debug, segment off, relocation on: debug address [31:7], zeros.
// - Refill, boot flag clear: base [63:12] with 0x000 or 0x180.
// - Refill, boot flag set: boot base plus 0x200 or 0x380.
// - Cache error: base with forced bit 29 and 0x100, or boot+0300.
// - Interrupt, flags clear: base plus 0x180, dedicated 0x200.
// - Interrupt, boot flag set: boot base plus 0380 or 0400.
// - Simultaneous conditions: only the highest priority one is taken.
// - Fixed priority: reset highest, load/store bus error lowest.
// - The taken exception's code is written to the cause code field, except for reset, NMI and debug.
// - Select bit 0 of reset base set: reset uses the boot base.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module exception_vector_select #(
   parameter logic [4:0] TLB_REFILL_CODE = 5'h02,
   parameter logic [4:0] CACHE_ERR_CODE  = 5'h1E,
   parameter logic [4:0] BUS_ERR_CODE    = 5'h07
) (
   input  wire logic                  sys_clk,       // Core clock
   input  wire logic                  rst,           // Async reset
   input  wire logic                  hsel,          // Slave select
   input  wire logic [31:0]           haddr,         // Byte address
   input  wire logic [1:0]            htrans,        // Transfer type
   input  wire logic                  hwrite,        // Write access
   input  wire logic [2:0]            hsize,         // Transfer size
   input  wire logic [31:0]           hwdata,        // Write data
   input  wire logic                  hready,        // Bus ready
   output logic                       hreadyout,     // Never stalls
   output logic                       hresp,         // Always OKAY
   output logic      [31:0]           hrdata,        // Read data
   input  wire logic [7:0]            excRaise,      // Raised classes
   input  wire exception_vector_pkg::exc_flags_t excFlags, // Mode flags
   input  wire logic [63:0]           exceptionBase, // Exception base
   input  wire logic [31:0]           debugVectorAddress, // Debug addr
   input  wire logic [4:0]            otherCode,     // Code for others
   output logic                       vectorValid,   // Taken pulse
   output exception_vector_pkg::vector_result_t taken // Taken result
);

   // ****************************************************************
   // Register bus
   // ****************************************************************
   logic [31:0] vpResetBase_reg, vpResetBase_next;
   logic [31:0] bootBase_reg, bootBase_next;
   logic        wrPending_reg, wrPending_next;
   logic [11:0] wrAddr_reg, wrAddr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [63:0] lastVector_reg, lastVector_next;
   exception_vector_pkg::exc_class_t lastClass_reg, lastClass_next;
   logic [4:0]  lastCode_reg, lastCode_next;
   logic        addrPhase;
   logic [11:0] addrOfs;
   logic [31:0] curReset, curBoot;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;
   assign addrPhase = hsel & htrans[1] & hready;
   // Only the low offset bits decode; the window repeats above 4 KB
   assign addrOfs   = {haddr[11:2], 2'b00};

   // A read right behind a write sees the new value, not the stale one
   always_comb begin
      curReset = vpResetBase_reg;
      curBoot  = bootBase_reg;
      if (wrPending_reg && wrAddr_reg == exception_vector_pkg::VP_RESET_BASE_OFS) begin
         curReset = hwdata;
      end
      if (wrPending_reg && wrAddr_reg == exception_vector_pkg::CORE_BOOT_BASE_OFS) begin
         curBoot = hwdata;
      end
   end

   always_comb begin
      vpResetBase_next = curReset;
      bootBase_next    = curBoot;
      wrPending_next   = addrPhase & hwrite & (hsize == 3'b010);
      wrAddr_next      = addrOfs;
      rdata_next       = rdata_reg;
      if (addrPhase && !hwrite) begin
         if (addrOfs == exception_vector_pkg::VP_RESET_BASE_OFS) begin
            rdata_next = curReset;
         end else if (addrOfs == exception_vector_pkg::CORE_BOOT_BASE_OFS) begin
            rdata_next = curBoot;
         end else if (addrOfs == exception_vector_pkg::LAST_VECTOR_LO_OFS) begin
            rdata_next = lastVector_reg[31:0];
         end else if (addrOfs == exception_vector_pkg::LAST_VECTOR_HI_OFS) begin
            rdata_next = lastVector_reg[63:32];
         end else if (addrOfs == exception_vector_pkg::TAKEN_STATUS_OFS) begin
            rdata_next = '0;
            rdata_next[4:0] = lastCode_reg;
            rdata_next[exception_vector_pkg::CLASS_FIELD_LSB +: 3] = lastClass_reg;
         end else begin
            rdata_next = '0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vpResetBase_reg <= exception_vector_pkg::VP_RESET_BASE_RST;
         bootBase_reg    <= exception_vector_pkg::CORE_BOOT_BASE_RST;
         wrPending_reg   <= 1'b0;
         wrAddr_reg      <= 12'h000;
         rdata_reg       <= 32'h0000_0000;
      end else begin
         vpResetBase_reg <= vpResetBase_next;
         bootBase_reg    <= bootBase_next;
         wrPending_reg   <= wrPending_next;
         wrAddr_reg      <= wrAddr_next;
         rdata_reg       <= rdata_next;
      end
   end

   // ****************************************************************
   // Priority pick
   // ****************************************************************
   logic [7:0] grant;
   logic [2:0] pickIdx;
   logic       pickValid;
   exception_vector_pkg::exc_class_t pickClass;

   exception_priority_pick #(
      .N (exception_vector_pkg::NUM_CLASSES)
   ) uPick (
      .raise (excRaise),
      .grant (grant),
      .index (pickIdx),
      .any   (pickValid)
   );

   assign pickClass = exception_vector_pkg::exc_class_t'(pickIdx);

   // ****************************************************************
   // Vector selection
   // ****************************************************************
   logic [63:0] ebaseGen, bootVec, resetVec, vecSel;
   logic [4:0]  codeSel;
   logic        codeWr;
   logic        boot_vector_flag, exception_level_flag, iv;

   assign boot_vector_flag      = excFlags.bootVectorFlag;
   assign exception_level_flag      = excFlags.exceptionLevelFlag;
   assign iv       = excFlags.dedicatedInterruptVectorFlag;
   assign ebaseGen = {exceptionBase[63:12], 12'h000};
   assign bootVec  = {exception_vector_pkg::UPPER_ONES, curBoot[31:12], 12'h000};

   // Select bit chooses between the local and the shared base
   always_comb begin
      if (curReset[exception_vector_pkg::USE_BOOT_BASE_BIT]) begin
         resetVec = bootVec;
      end else begin
         resetVec = {exception_vector_pkg::UPPER_ONES, curReset[31:12], 12'h000};
      end
   end

   always_comb begin
      vecSel  = ebaseGen | 64'(exception_vector_pkg::OFS_GENERAL);
      codeSel = otherCode;
      codeWr  = 1'b1;
      case (pickClass)
         exception_vector_pkg::CLS_RESET: begin
            vecSel = resetVec;
            codeWr = 1'b0;
         end
         exception_vector_pkg::CLS_NMI: begin
            vecSel = exception_vector_pkg::NMI_VECTOR;
            codeWr = 1'b0;
         end
         exception_vector_pkg::CLS_DEBUG: begin
            codeWr = 1'b0;
            if (!excFlags.debugSegmentEnable) begin
               if (excFlags.relocatedDebugVectorEnable) begin
                  vecSel = {exception_vector_pkg::UPPER_ONES,
                            debugVectorAddress[31:7], 7'b000_0000};
               end else begin
                  vecSel = exception_vector_pkg::DEBUG_FIXED_VECTOR;
               end
            end else if (excFlags.probeTrapSelect) begin
               vecSel = exception_vector_pkg::PROBE_VECTOR;
            end else if (boot_vector_flag) begin
               vecSel = bootVec + 64'(exception_vector_pkg::BOOT_OFS_GENERAL);
            end
         end
         exception_vector_pkg::CLS_CACHE_ERR: begin
            codeSel = CACHE_ERR_CODE;
            if (boot_vector_flag) begin
               vecSel = bootVec + 64'(exception_vector_pkg::BOOT_OFS_CACHE_ERR);
            end else begin
               vecSel = {exceptionBase[63:30], 1'b1, exceptionBase[28:12],
                         exception_vector_pkg::OFS_CACHE_ERR};
            end
         end
         exception_vector_pkg::CLS_TLB_REFILL: begin
            codeSel = TLB_REFILL_CODE;
            if (boot_vector_flag) begin
               vecSel = bootVec + 64'(exception_level_flag ? exception_vector_pkg::BOOT_OFS_TLB_LEVEL
                                          : exception_vector_pkg::BOOT_OFS_TLB);
            end else begin
               vecSel = ebaseGen | 64'(exception_level_flag ? exception_vector_pkg::OFS_GENERAL
                                           : exception_vector_pkg::OFS_TLB_REFILL);
            end
         end
         exception_vector_pkg::CLS_INTERRUPT: begin
            codeSel = exception_vector_pkg::EXC_CODE_INTERRUPT;
            if (boot_vector_flag) begin
               vecSel = bootVec + 64'((iv && !exception_level_flag) ? exception_vector_pkg::BOOT_OFS_INT_DEDIC
                                                   : exception_vector_pkg::BOOT_OFS_GENERAL);
            end else begin
               vecSel = ebaseGen | 64'((iv && !exception_level_flag) ? exception_vector_pkg::OFS_INT_DEDICATED
                                                    : exception_vector_pkg::OFS_GENERAL);
            end
         end
         default: begin
            if (pickClass == exception_vector_pkg::CLS_BUS_ERR) begin
               codeSel = BUS_ERR_CODE;
            end
            if (boot_vector_flag) begin
               vecSel = bootVec + 64'(exception_vector_pkg::BOOT_OFS_GENERAL);
            end
         end
      endcase
   end

   // ****************************************************************
   // Result registers
   // ****************************************************************
   logic                                 valid_reg, valid_next;
   exception_vector_pkg::vector_result_t taken_reg, taken_next;

   always_comb begin
      valid_next      = pickValid;
      taken_next      = taken_reg;
      lastVector_next = lastVector_reg;
      lastClass_next  = lastClass_reg;
      lastCode_next   = lastCode_reg;
      if (pickValid) begin
         taken_next.vector    = vecSel;
         taken_next.cls       = pickClass;
         taken_next.codeWrite = codeWr;
         lastVector_next      = vecSel;
         lastClass_next       = pickClass;
         if (codeWr) begin
            taken_next.code = codeSel;
            lastCode_next   = codeSel;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         valid_reg      <= 1'b0;
         taken_reg      <= '0;
         lastVector_reg <= 64'h0000_0000_0000_0000;
         lastClass_reg  <= exception_vector_pkg::CLS_RESET;
         lastCode_reg   <= 5'h00;
      end else begin
         valid_reg      <= valid_next;
         taken_reg      <= taken_next;
         lastVector_reg <= lastVector_next;
         lastClass_reg  <= lastClass_next;
         lastCode_reg   <= lastCode_next;
      end
   end

   assign vectorValid = valid_reg;
   assign taken       = taken_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence sPick(exception_vector_pkg::exc_class_t c);
      pickValid && pickClass == c;
   endsequence

   sequence sOut(logic [63:0] v);
      vectorValid && taken.vector == v;
   endsequence

   a_reset_local_base: assert property (
      sPick(exception_vector_pkg::CLS_RESET) ##0 !curReset[0]
      |=> sOut({32'hFFFF_FFFF, $past(curReset[31:12]), 12'h000}))
      else $error("reset vector not from local base");
   a_reset_boot_select: assert property (
      sPick(exception_vector_pkg::CLS_RESET) ##0 curReset[0]
      |=> sOut({32'hFFFF_FFFF, $past(curBoot[31:12]), 12'h000}))
      else $error("reset select did not use boot base");
   a_debug_fixed_vec: assert property (
      sPick(exception_vector_pkg::CLS_DEBUG) ##0 (!excFlags.debugSegmentEnable
      && !excFlags.relocatedDebugVectorEnable)
      |=> sOut(64'hFFFF_FFFF_BFC0_0480))
      else $error("debug fixed vector wrong");
   a_debug_reloc_vec: assert property (
      sPick(exception_vector_pkg::CLS_DEBUG) ##0 (!excFlags.debugSegmentEnable
      && excFlags.relocatedDebugVectorEnable)
      |=> vectorValid && taken.vector[31:7] == $past(debugVectorAddress[31:7])
          && taken.vector[6:0] == 7'h00)
      else $error("relocated debug vector wrong");
   a_refill_exception_base_register: assert property (
      sPick(exception_vector_pkg::CLS_TLB_REFILL) ##0 !boot_vector_flag
      |=> taken.vector[63:12] == $past(exceptionBase[63:12])
          && taken.vector[11:0] == ($past(exception_level_flag) ? 12'h180 : 12'h000))
      else $error("refill vector wrong");
   a_cache_err_bit: assert property (
      sPick(exception_vector_pkg::CLS_CACHE_ERR) ##0 !boot_vector_flag
      |=> taken.vector[29] && taken.vector[11:0] == 12'h100)
      else $error("cache error vector wrong");
   a_int_dedicated: assert property (
      sPick(exception_vector_pkg::CLS_INTERRUPT) ##0 (!boot_vector_flag && !exception_level_flag && iv)
      |=> taken.vector[11:0] == 12'h200 && taken.code == 5'h00
          && taken.codeWrite)
      else $error("dedicated interrupt vector wrong");
   a_nmi_fixed: assert property (excRaise[1:0] == 2'b10
      |=> sOut(64'hFFFF_FFFF_BFC0_0000)
          ##0 taken.cls == exception_vector_pkg::CLS_NMI)
      else $error("nmi vector wrong");
   a_reset_wins: assert property (excRaise[0] |=> vectorValid
      && taken.cls == exception_vector_pkg::CLS_RESET && !taken.codeWrite)
      else $error("reset did not win");
   a_single_taken: assert property (vectorValid == $past(|excRaise)
      && (!vectorValid || ($past(excRaise) & (8'h01 << taken.cls)) != 8'h00)
      && ($past(excRaise) & ((8'h01 << taken.cls) - 8'h01)) == 8'h00)
      else $error("taken class was not raised");

endmodule // exception_vector_select
`default_nettype wire

// File: test/exception_pipeline_model.sv
// Purpose: Pipeline side that reports exception classes to the selector
// Assumes: Its outputs change only just after rising edges of sys_clk
// Notes:   Bases and codes stay fixed; each raise lasts exactly one cycle
`timescale 1ns/1ps
`default_nettype none
module exception_pipeline_model (
   input  wire logic                        sys_clk,            // Core clock
   output logic [7:0]                       excRaise,           // Classes
   output exception_vector_pkg::exc_flags_t excFlags,           // Mode flags
   output logic [63:0]                      exceptionBase,      // Base
   output logic [31:0]                      debugVectorAddress, // Debug
   output logic [4:0]                       otherCode           // Code
);
   initial begin
      excRaise = 8'h00;
      excFlags = '0;
      exceptionBase = 64'h1234_5678_9ABC_D000;
      debugVectorAddress = 32'h8765_43FF;
      otherCode = 5'h0D;
   end

   // Quiet cycle after each raise, so every take is judged on its own
   task automatic fire(input logic [7:0] r, input logic [5:0] f);
      @(posedge sys_clk);
      excRaise <= r;
      excFlags <= f;
      @(posedge sys_clk);
      excRaise <= 8'h00;
   endtask
endmodule // exception_pipeline_model
`default_nettype wire

// File: test/tb_exception_vector_select.sv
// Purpose: Self-checking bench for the exception vector selector
// Assumes: Zero-wait slave; result one cycle after the raise
// Notes:   Boot base is reprogrammed so boot vectors differ from reset
`timescale 1ns/1ps
`default_nettype none
module tb_exception_vector_select;
   localparam logic [31:0] BB = 32'h1FC3_4000;
   logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, vectorValid;
   logic [31:0] haddr, hwdata, hrdata, dva, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  excRaise;
   logic [63:0] eb, bv;
   logic [4:0]  oc;
   exception_vector_pkg::exc_flags_t     excFlags;
   exception_vector_pkg::vector_result_t taken;
   int          fail_count = 0;
   int          total_checks = 0;

   exception_vector_select u_exception_vector_select (.sys_clk(sys_clk),
      .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .excRaise(excRaise), .excFlags(excFlags), .exceptionBase(eb),
      .debugVectorAddress(dva), .otherCode(oc), .vectorValid(vectorValid),
      .taken(taken));
   exception_pipeline_model u_exception_pipeline_model (.sys_clk(sys_clk),
      .excRaise(excRaise), .excFlags(excFlags), .exceptionBase(eb),
      .debugVectorAddress(dva), .otherCode(oc));

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Bounded wait for hready, so a stalled slave cannot hang the run
   task automatic wait_ready();
      int n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         fail_count++;
         $display("[FAIL] %0t bus never ready", $time);
         final_report();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      r = hrdata;
   endtask
   task automatic exc(input logic [7:0] r, input logic [5:0] f,
                      input logic [63:0] ev);
      u_exception_pipeline_model.fire(r, f);
      #1;
      chk(64'(vectorValid), 64'h1, "valid pulse");
      chk(taken.vector, ev, "vector");
      @(posedge sys_clk);
      #1;
      chk(64'(vectorValid), 64'h0, "pulse ends");
   endtask

   task automatic t_regs();
      ahb(1'b0, 32'h0000_0020, 32'h0, q);
      chk(64'(q), 64'hBFC0_0000, "reset base default");
      chk(64'(hresp), 64'h0, "okay response");
      ahb(1'b0, 32'h0000_0680, 32'h0, q);
      chk(64'(q), 64'hBFC0_0000, "boot base default");
      ahb(1'b0, 32'h0000_0100, 32'h0, q);
      chk(64'(q), 64'h0, "unmapped read");
      ahb(1'b1, 32'h0000_0680, BB, q);
      ahb(1'b1, 32'h0000_0020, 32'h1234_5000, q);
      ahb(1'b0, 32'h0000_0020, 32'h0, q);
      chk(64'(q), 64'h1234_5000, "reset base back");
      exc(8'h01, 6'b10_0000, 64'hFFFF_FFFF_1234_5000);
      ahb(1'b1, 32'h0000_0020, 32'h1234_5001, q);
      exc(8'h01, 6'b00_0000, bv);
      ahb(1'b0, 32'h0000_0704, 32'h0, q);
      chk(64'(q), 64'hFFFF_FFFF, "last vector high");
   endtask

   task automatic t_vectors();
      exc(8'h02, 6'b11_1111, 64'hFFFF_FFFF_BFC0_0000);
      exc(8'h04, 6'b11_1000, 64'hFFFF_FFFF_BFC0_0480);
      exc(8'h04, 6'b00_0001, {32'hFFFF_FFFF, dva[31:7], 7'h00});
      exc(8'h04, 6'b00_0110, 64'hFFFF_FFFF_FF20_0200);
      exc(8'h10, 6'b00_0000, {eb[63:12], 12'h000});
      exc(8'h10, 6'b01_0000, {eb[63:12], 12'h180});
      exc(8'h10, 6'b10_0000, bv + 64'h200);
      exc(8'h10, 6'b11_0000, bv + 64'h380);
      exc(8'h08, 6'b01_0000, {eb[63:30], 1'b1, eb[28:12], 12'h100});
      exc(8'h08, 6'b10_0000, bv + 64'h300);
      exc(8'h20, 6'b00_0000, {eb[63:12], 12'h180});
      exc(8'h20, 6'b00_1000, {eb[63:12], 12'h200});
      exc(8'h20, 6'b10_0000, bv + 64'h380);
      exc(8'h20, 6'b10_1000, bv + 64'h400);
      exc(8'h40, 6'b01_1000, {eb[63:12], 12'h180});
      exc(8'h40, 6'b10_0000, bv + 64'h380);
   endtask

   task automatic t_priority();
      exc(8'hFF, 6'b01_1111, bv);
      chk(64'(taken.cls), 64'(exception_vector_pkg::CLS_RESET), "cls");
      exc(8'h18, 6'b00_0000, {eb[63:30], 1'b1, eb[28:12], 12'h100});
      chk(64'(taken.code), 64'h1E, "cache code");
      exc(8'h02, 6'b00_0000, 64'hFFFF_FFFF_BFC0_0000);
      chk(64'(taken.code), 64'h1E, "code kept on NMI");
      exc(8'h30, 6'b00_0000, {eb[63:12], 12'h000});
      chk(64'(taken.code), 64'h2, "refill code");
      exc(8'hE0, 6'b00_1000, {eb[63:12], 12'h200});
      chk(64'(taken.code), 64'h0, "interrupt code");
      exc(8'hC0, 6'b00_0000, {eb[63:12], 12'h180});
      chk(64'(taken.code), 64'(oc), "other code");
      exc(8'h80, 6'b00_0000, {eb[63:12], 12'h180});
      ahb(1'b0, 32'h0000_0708, 32'h0, q);
      chk(64'(q), 64'h0000_0707, "status bus error");
   endtask

   // Mid-run reset must bring back the defaults and clear the result
   task automatic t_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk(64'(vectorValid), 64'h0, "valid after reset");
      chk(taken.vector, 64'h0, "vector after reset");
      ahb(1'b0, 32'h0000_0020, 32'h0, q);
      chk(64'(q), 64'hBFC0_0000, "reset base after reset");
      ahb(1'b0, 32'h0000_0704, 32'h0, q);
      chk(64'(q), 64'h0, "last vector cleared");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      bv = {32'hFFFF_FFFF, BB[31:12], 12'h000};
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_vectors();
      t_priority();
      t_reset();
      final_report();
   end
   initial begin
      #100000;
      fail_count++;
      $display("[FAIL] %0t run timeout", $time);
      final_report();
   end
endmodule // tb_exception_vector_select
`default_nettype wire
